// >>> bench/timer_pulse_pwm_modes_test.sv
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module timer_pulse_pwm_modes_test
    import tpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, halt = 1'b0, cpu_mask = 1'b0, l;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, rdata, v;
    logic [1:0]  fire = 2'h0;
    logic        cap1_pin, cap2_pin, ext_clk_pin, cmp1_pin_o, cmp1_pin_oe, cmp2_pin_o, cmp2_pin_oe, irq;
    logic [15:0] w, frz;
    logic [11:0] rst_q[$] = '{12'h200, 12'h000, 12'h100, 12'h580, 12'h600, 12'hD80, 12'hE00, 12'hF00};
    int          bad_count = 0, cmp_count = 0, cyc_n = 0, want, t0, t1, t2, t3;

    tpm_timer #(.ADDR_W(4)) DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cap1_pin(cap1_pin), .cap2_pin(cap2_pin), .ext_clk_pin(ext_clk_pin),
        .cmp1_pin_o(cmp1_pin_o), .cmp1_pin_oe(cmp1_pin_oe), .cmp2_pin_o(cmp2_pin_o),
        .cmp2_pin_oe(cmp2_pin_oe), .halt(halt), .cpu_mask(cpu_mask), .irq(irq));
    tpm_pins u_pins (.clk(clk), .rst_n(rst_n), .fire(fire), .cap1_pin(cap1_pin), .cap2_pin(cap2_pin),
        .ext_clk_pin(ext_clk_pin));

    // Clock and cycle stamp
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc_n <= cyc_n + 1;

    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wreg

    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clk);
    endtask : rreg

    task automatic r16(input logic [3:0] a, output logic [15:0] d);
        logic [7:0] b;
        rreg(a, b);
        d[15:8] = b;
        rreg(a + 4'h1, b);
        d[7:0] = b;
    endtask : r16

    task automatic kick(input logic [1:0] m);
        fire <= m;
        @(posedge clk);
        fire <= 2'h0;
        @(posedge clk);
    endtask : kick

    // Waits for a first pin level and stamps the edge where it showed
    task automatic wait_pin(input logic lv, output int t);
        int k = 0;
        #1;
        while (cmp1_pin_o !== lv && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK("pin level", lv, cmp1_pin_o)
        t = cyc_n;
        @(posedge clk);
    endtask : wait_pin

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        want = $urandom(32'h2B98);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rst_q[i]) begin
            rreg(rst_q[i][11:8], v);
            `CHK("reset value", rst_q[i][7:0], v)
        end
        $display("reset test done");
        wreg(4'h1, 8'hC4);
        l = 1'($urandom);
        repeat (2) begin
            wreg(4'h0, {7'h24, l});
            repeat (2) @(posedge clk);
            `CHK("forced pin", l, cmp1_pin_o)
            `CHK("pin enable", 1'b1, cmp1_pin_oe)
            l = !l;
        end
        rreg(4'h2, v);
        `CHK("cmp1 flag", 1'b0, v[6])
        `CHK("irq", 1'b0, irq)
        $display("force test done");
        want = 12 + int'($urandom % 8);
        wreg(4'h5, 8'h00);
        wreg(4'h6, 8'(want - 5));
        wreg(4'h0, 8'h8E);
        wreg(4'h1, 8'hA6);
        kick(2'h1);
        wait_pin(1'b1, t0);
        wait_pin(1'b0, t1);
        `CHK("pulse", 1'b1, (t1 - t0 >= 2 * want - 2) && (t1 - t0 <= 2 * want + 1))
        kick(2'h2);
        rreg(4'h2, v);
        `CHK("cap1 flag", 1'b1, v[7])
        `CHK("cmp1 flag", 1'b0, v[6])
        `CHK("cap2 flag", 1'b1, v[4])
        `CHK("irq", 1'b1, irq)
        r16(4'h3, w);
        `CHK("cap1 word", 16'hFFFD, w)
        rreg(4'h2, v);
        rreg(4'h4, v);
        rreg(4'h2, v);
        `CHK("cap1 clear", 1'b0, v[7])
        $display("one pulse test done");
        wreg(4'hD, 8'h00);
        wreg(4'hE, 8'h0A);
        wreg(4'h5, 8'h00);
        wreg(4'h6, 8'h04);
        wreg(4'h0, 8'h06);
        kick(2'h1);
        wreg(4'h1, 8'hB6);
        wait_pin(1'b0, t0);
        wait_pin(1'b1, t0);
        wreg(4'h5, 8'h00);
        wreg(4'h6, 8'h06);
        wait_pin(1'b0, t1);
        wait_pin(1'b1, t2);
        wait_pin(1'b0, t3);
        `CHK("pwm high", 18, t1 - t0)
        `CHK("pwm period", 30, t2 - t0)
        `CHK("new high", 22, t3 - t2)
        rreg(4'h2, v);
        `CHK("cap1 flag", 1'b1, v[7])
        `CHK("cmp flags", 2'h0, {v[6], v[3]})
        `CHK("irq", 1'b0, irq)
        $display("pwm test done");
        wreg(4'h1, 8'h06);
        wreg(4'h0, 8'h80);
        rreg(4'h2, v);
        rreg(4'h4, v);
        rreg(4'hC, v);
        rreg(4'h2, v);
        `CHK("flags clear", 2'h0, {v[7], v[4]})
        halt <= 1'b1;
        repeat (2) @(posedge clk);
        r16(4'h7, frz);
        kick(2'h2);
        r16(4'h7, w);
        `CHK("frozen count", frz, w)
        rreg(4'h2, v);
        `CHK("cap2 in halt", 1'b0, v[4])
        halt <= 1'b0;
        repeat (3) @(posedge clk);
        rreg(4'h2, v);
        `CHK("cap2 after halt", 1'b1, v[4])
        `CHK("irq", 1'b1, irq)
        cpu_mask <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("masked irq", 1'b0, irq)
        r16(4'hB, w);
        `CHK("cap2 word", 1'b1, w - frz <= 16'h0001)
        $display("halt test done");
        end_sim();
    end
endmodule : timer_pulse_pwm_modes_test
`default_nettype wire

// >>> bench/tpm_pins.sv
`default_nettype none
module tpm_pins (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Event requests
    input  wire logic [1:0] fire,
    // Pins into the timer
    output logic            cap1_pin,
    output logic            cap2_pin,
    output logic            ext_clk_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0][2:0] hold_q;

    // Each request gives a rising edge held a few cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (fire[i]) begin
                    hold_q[i] <= 3'h5;
                end else if (hold_q[i] != 3'h0) begin
                    hold_q[i] <= hold_q[i] - 3'h1;
                end
            end
        end
    end

    // Pin levels; external clock stands still
    assign cap1_pin    = hold_q[0] != 3'h0;
    assign cap2_pin    = hold_q[1] != 3'h0;
    assign ext_clk_pin = 1'b0;
endmodule : tpm_pins
`default_nettype wire

// >>> bench/tpm_timer_props.sv
`default_nettype none
`include "tpm_defs.svh"
module tpm_timer_props
    import tpm_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0]        wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [7:0]        rdata,
    // Pins and system state
    input wire logic              cap1_pin,
    input wire logic              cap2_pin,
    input wire logic              ext_clk_pin,
    input wire logic              cmp1_pin_o,
    input wire logic              cmp1_pin_oe,
    input wire logic              cmp2_pin_o,
    input wire logic              cmp2_pin_oe,
    input wire logic              halt,
    input wire logic              cpu_mask,
    input wire logic              irq
);
    logic [7:0] cr1_q;
    logic [7:0] cr2_q;
    logic       dis_q;
    logic       onep;
    logic       normal;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Shadow of the control bits written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr1_q <= 8'h00;
            cr2_q <= 8'h00;
            dis_q <= 1'b0;
        end else if (wr) begin
            if (addr == ADDR_W'(`TPM_A_CR1)) cr1_q <= wdata;
            if (addr == ADDR_W'(`TPM_A_CR2)) cr2_q <= wdata;
            if (addr == ADDR_W'(`TPM_A_SR)) dis_q <= wdata[`TPM_SR_DIS];
        end
    end

    // Mode decode
    assign onep   = cr2_q[`TPM_CR2_ONEP] && !cr2_q[`TPM_CR2_PWM];
    assign normal = !cr2_q[`TPM_CR2_ONEP] && !cr2_q[`TPM_CR2_PWM];

    property p_oe1_on;
        (cr2_q[`TPM_CR2_PIN1_EN] && !dis_q)[*2] |-> cmp1_pin_oe;
    endproperty
    a_oe1_on: assert property (p_oe1_on)
        else $error("first pin not driven while enabled");
    property p_oe1_off;
        (!cr2_q[`TPM_CR2_PIN1_EN])[*2] |-> !cmp1_pin_oe;
    endproperty
    a_oe1_off: assert property (p_oe1_off)
        else $error("first pin driven while disabled");
    property p_force;
        (normal && cr1_q[`TPM_CR1_FORCE1] && $stable(cr1_q))[*3] |-> cmp1_pin_o == cr1_q[`TPM_CR1_LVL1];
    endproperty
    a_force: assert property (p_force)
        else $error("forced level not on first pin");
    property p_oe2_mode;
        (cr2_q[`TPM_CR2_ONEP] || cr2_q[`TPM_CR2_PWM])[*2] |-> !cmp2_pin_oe;
    endproperty
    a_oe2_mode: assert property (p_oe2_mode)
        else $error("second pin driven in waveform mode");
    property p_trig;
        onep && !dis_q && !halt && cr1_q[`TPM_CR1_EDGE1] && $rose(cap1_pin) |=> cmp1_pin_o == cr1_q[`TPM_CR1_LVL2];
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger edge did not start pulse");
    property p_mask;
        cpu_mask |=> !irq;
    endproperty
    a_mask: assert property (p_mask)
        else $error("irq raised while masked");
    property p_noen;
        (cr1_q[7:5] == 3'h0)[*2] |-> !irq;
    endproperty
    a_noen: assert property (p_noen)
        else $error("irq raised with no enable");
    property p_halt;
        halt[*2] |-> $stable(cmp1_pin_o) && $stable(cmp2_pin_o);
    endproperty
    a_halt: assert property (p_halt)
        else $error("pin moved during halt");
endmodule : tpm_timer_props

bind tpm_timer tpm_timer_props #(.ADDR_W(ADDR_W)) u_props (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cap1_pin(cap1_pin), .cap2_pin(cap2_pin), .ext_clk_pin(ext_clk_pin),
    .cmp1_pin_o(cmp1_pin_o), .cmp1_pin_oe(cmp1_pin_oe), .cmp2_pin_o(cmp2_pin_o),
    .cmp2_pin_oe(cmp2_pin_oe), .halt(halt), .cpu_mask(cpu_mask), .irq(irq)
);
`default_nettype wire

// >>> src/tpm_cmp.sv
`default_nettype none
`include "tpm_defs.svh"
module tpm_cmp
    import tpm_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Link to the timer core
    tpm_cmp_if.unit   c
);
    tpm_word_t written_q;
    tpm_word_t active_q;
    logic      inhibit_q;

    // Software copy of the compare word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            written_q <= `TPM_CMP_RST;
        end else if (c.wr_hi) begin
            written_q <= {c.wdata, written_q[7:0]};
        end else if (c.wr_lo) begin
            written_q <= {written_q[15:8], c.wdata};
        end
    end

    // High byte write blocks compares until low byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_q <= 1'b0;
        end else if (c.wr_hi) begin
            inhibit_q <= 1'b1;
        end else if (c.wr_lo) begin
            inhibit_q <= 1'b0;
        end
    end

    // Working copy; in PWM only taken at period end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= `TPM_CMP_RST;
        end else if (!inhibit_q && (!c.pwm || c.period_end)) begin
            active_q <= written_q;
        end
    end

    // Match on a counter tick
    always_comb begin
        c.value = written_q;
        c.match = c.tick && !inhibit_q && (active_q == c.cnt);
    end
endmodule : tpm_cmp
`default_nettype wire

// >>> src/tpm_cmp_if.sv
`default_nettype none
interface tpm_cmp_if;
    logic        wr_hi;
    logic        wr_lo;
    logic [7:0]  wdata;
    logic        pwm;
    logic        period_end;
    logic        tick;
    logic [15:0] cnt;
    logic [15:0] value;
    logic        match;

    modport timer (output wr_hi, wr_lo, wdata, pwm, period_end, tick, cnt,
                   input value, match);
    modport unit  (input wr_hi, wr_lo, wdata, pwm, period_end, tick, cnt,
                   output value, match);
endinterface : tpm_cmp_if
`default_nettype wire

// >>> src/tpm_defs.svh
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH

// Register addresses on the byte port
`define TPM_A_CR1        4'h0
`define TPM_A_CR2        4'h1
`define TPM_A_SR         4'h2
`define TPM_A_IC1H       4'h3
`define TPM_A_IC1L       4'h4
`define TPM_A_OC1H       4'h5
`define TPM_A_OC1L       4'h6
`define TPM_A_CNTH       4'h7
`define TPM_A_CNTL       4'h8
`define TPM_A_ACNTH      4'h9
`define TPM_A_ACNTL      4'hA
`define TPM_A_IC2H       4'hB
`define TPM_A_IC2L       4'hC
`define TPM_A_OC2H       4'hD
`define TPM_A_OC2L       4'hE

// First control register fields
`define TPM_CR1_CAP_IE   7
`define TPM_CR1_CMP_IE   6
`define TPM_CR1_OVF_IE   5
`define TPM_CR1_FORCE2   4
`define TPM_CR1_FORCE1   3
`define TPM_CR1_LVL2     2
`define TPM_CR1_EDGE1    1
`define TPM_CR1_LVL1     0

// Second control register fields
`define TPM_CR2_PIN1_EN  7
`define TPM_CR2_PIN2_EN  6
`define TPM_CR2_ONEP     5
`define TPM_CR2_PWM      4
`define TPM_CR2_PRE_HI   3
`define TPM_CR2_PRE_LO   2
`define TPM_CR2_EDGE2    1
`define TPM_CR2_EXT_EDGE 0

// Status register fields
`define TPM_SR_CAP1      7
`define TPM_SR_CMP1      6
`define TPM_SR_OVF       5
`define TPM_SR_CAP2      4
`define TPM_SR_CMP2      3
`define TPM_SR_DIS       2

// Prescaler codes
`define TPM_PRE_DIV4     2'h0
`define TPM_PRE_DIV2     2'h1
`define TPM_PRE_DIV8     2'h2
`define TPM_PRE_EXT      2'h3

// Reset, load and top values
`define TPM_CR_RST       8'h00
`define TPM_CMP_RST      16'h8000
`define TPM_CNT_RST      16'hFFFC
`define TPM_CNT_LOAD     16'hFFFC
`define TPM_CAP_LOAD     16'hFFFD
`define TPM_CNT_TOP      16'hFFFF

`endif

// >>> src/tpm_edge.sv
`default_nettype none
`include "tpm_defs.svh"
module tpm_edge
    import tpm_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin and edge choice
    input  wire logic pin,
    input  wire logic rise_sel,
    // Detected edge
    output logic      edge_p
);
    logic pin_q;

    // Previous pin level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin;
        end
    end

    // Selected transition, one cycle long
    always_comb begin
        edge_p = rise_sel ? (pin & ~pin_q) : (~pin & pin_q);
    end
endmodule : tpm_edge
`default_nettype wire

// >>> src/tpm_pkg.sv
`default_nettype none
package tpm_pkg;
    // Waveform mode of the timer
    typedef enum logic [1:0] {
        TPM_NORMAL,
        TPM_ONEP,
        TPM_PWM
    } tpm_mode_t;

    typedef logic [15:0] tpm_word_t;
endpackage : tpm_pkg
`default_nettype wire

// >>> src/tpm_timer.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`default_nettype none
`include "tpm_defs.svh"
module tpm_timer
    import tpm_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [7:0]        rdata,
    // Event pins
    input  wire logic              cap1_pin,
    input  wire logic              cap2_pin,
    input  wire logic              ext_clk_pin,
    // Waveform pins
    output logic                   cmp1_pin_o,
    output logic                   cmp1_pin_oe,
    output logic                   cmp2_pin_o,
    output logic                   cmp2_pin_oe,
    // System state
    input  wire logic              halt,
    input  wire logic              cpu_mask,
    output logic                   irq
);
    if (ADDR_W < 4) begin : g_chk
        $error("tpm_timer: ADDR_W must be at least 4");
    end

    logic [7:0]  cr1_q;
    logic [7:0]  cr2_q;
    logic        dis_q;
    logic [7:0]  flag_q;
    logic [7:0]  clr_arm_q;
    logic [7:0]  flag_set;
    logic [7:0]  flag_clr;
    tpm_word_t   cnt_q;
    tpm_word_t   ic1_q;
    tpm_word_t   ic2_q;
    logic [1:0]  cap_inh_q;
    logic [1:0]  halt_arm_q;
    logic [2:0]  pre_q;
    logic        pin1_q;
    logic        pin2_q;
    logic        oe1_q;
    logic        oe2_q;
    logic        irq_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rd_mux;
    logic        tick;
    logic        ext_edge;
    logic        cap1_edge;
    logic        cap2_edge;
    logic        cap1_ev;
    logic        cap2_ev;
    logic        trig;
    logic        reload;
    logic        ovf;
    logic        run;
    tpm_mode_t   mode;
    logic [3:0]  a;

    tpm_cmp_if cmp1_if ();
    tpm_cmp_if cmp2_if ();

    assign a = addr[3:0];

    // Edge detectors for the three event pins
    tpm_edge u_edge_cap1 (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin      (cap1_pin),
        .rise_sel (cr1_q[`TPM_CR1_EDGE1]),
        .edge_p   (cap1_edge)
    );
    tpm_edge u_edge_cap2 (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin      (cap2_pin),
        .rise_sel (cr2_q[`TPM_CR2_EDGE2]),
        .edge_p   (cap2_edge)
    );
    tpm_edge u_edge_ext (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin      (ext_clk_pin),
        .rise_sel (cr2_q[`TPM_CR2_EXT_EDGE]),
        .edge_p   (ext_edge)
    );

    // Compare units
    tpm_cmp u_cmp1 (
        .clk   (clk),
        .rst_n (rst_n),
        .c     (cmp1_if)
    );
    tpm_cmp u_cmp2 (
        .clk   (clk),
        .rst_n (rst_n),
        .c     (cmp2_if)
    );

    // Mode decode, PWM wins over one-pulse
    always_comb begin
        if (cr2_q[`TPM_CR2_PWM]) begin
            mode = TPM_PWM;
        end else if (cr2_q[`TPM_CR2_ONEP]) begin
            mode = TPM_ONEP;
        end else begin
            mode = TPM_NORMAL;
        end
    end

    // Counting stops in halt or when disabled
    assign run = !halt && !dis_q;

    // Prescaler divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 3'h0;
        end else if (run) begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // Counter tick per prescaler choice
    always_comb begin
        case (cr2_q[`TPM_CR2_PRE_HI:`TPM_CR2_PRE_LO])
            `TPM_PRE_DIV2: tick = run && (pre_q[0] == 1'b1);
            `TPM_PRE_DIV4: tick = run && (pre_q[1:0] == 2'h3);
            `TPM_PRE_DIV8: tick = run && (pre_q == 3'h7);
            default:       tick = run && ext_edge;
        endcase
    end

    // Compare unit links
    always_comb begin
        cmp1_if.wr_hi      = wr && (a == `TPM_A_OC1H);
        cmp1_if.wr_lo      = wr && (a == `TPM_A_OC1L);
        cmp1_if.wdata      = wdata;
        cmp1_if.pwm        = (mode == TPM_PWM);
        cmp1_if.period_end = cmp2_if.match && (mode == TPM_PWM);
        cmp1_if.tick       = tick;
        cmp1_if.cnt        = cnt_q;
        cmp2_if.wr_hi      = wr && (a == `TPM_A_OC2H);
        cmp2_if.wr_lo      = wr && (a == `TPM_A_OC2L);
        cmp2_if.wdata      = wdata;
        cmp2_if.pwm        = (mode == TPM_PWM);
        cmp2_if.period_end = cmp2_if.match && (mode == TPM_PWM);
        cmp2_if.tick       = tick;
        cmp2_if.cnt        = cnt_q;
    end

    // Capture events, held over halt until its exit
    always_comb begin
        cap1_ev = !halt && (cap1_edge || halt_arm_q[0]);
        cap2_ev = !halt && (cap2_edge || halt_arm_q[1]);
        trig    = (mode == TPM_ONEP) && !halt && !dis_q && cap1_edge;
        reload  = trig || ((mode == TPM_PWM) && cmp2_if.match);
        ovf     = tick && !reload && (cnt_q == `TPM_CNT_TOP);
    end

    // Capture edges during halt arm the logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_arm_q <= 2'h0;
        end else if (halt) begin
            halt_arm_q <= halt_arm_q | {cap2_edge, cap1_edge && (mode == TPM_NORMAL)};
        end else begin
            halt_arm_q <= 2'h0;
        end
    end

    // Free running counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `TPM_CNT_RST;
        end else if (reload) begin
            cnt_q <= `TPM_CNT_LOAD;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Capture reads of the high byte freeze transfers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_inh_q <= 2'h0;
        end else begin
            if (rd && (a == `TPM_A_IC1H)) begin
                cap_inh_q[0] <= 1'b1;
            end else if (rd && (a == `TPM_A_IC1L)) begin
                cap_inh_q[0] <= 1'b0;
            end
            if (rd && (a == `TPM_A_IC2H)) begin
                cap_inh_q[1] <= 1'b1;
            end else if (rd && (a == `TPM_A_IC2L)) begin
                cap_inh_q[1] <= 1'b0;
            end
        end
    end

    // First capture register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ic1_q <= 16'h0000;
        end else if (trig) begin
            ic1_q <= `TPM_CAP_LOAD;
        end else if ((mode == TPM_NORMAL) && cap1_ev && !cap_inh_q[0]) begin
            ic1_q <= cnt_q;
        end
    end

    // Second capture register works in every mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ic2_q <= 16'h0000;
        end else if (cap2_ev && !cap_inh_q[1]) begin
            ic2_q <= cnt_q;
        end
    end

    // Hardware flag sets per mode
    always_comb begin
        flag_set                = 8'h00;
        flag_set[`TPM_SR_CAP1]  = trig
                                || ((mode == TPM_PWM) && cmp2_if.match)
                                || ((mode == TPM_NORMAL) && cap1_ev && !cap_inh_q[0]);
        flag_set[`TPM_SR_CMP1]  = (mode == TPM_NORMAL) && cmp1_if.match;
        flag_set[`TPM_SR_OVF]   = ovf;
        flag_set[`TPM_SR_CAP2]  = cap2_ev && !cap_inh_q[1];
        flag_set[`TPM_SR_CMP2]  = (mode != TPM_PWM) && cmp2_if.match;
    end

    // Low byte accesses that complete a clear
    always_comb begin
        flag_clr                = 8'h00;
        flag_clr[`TPM_SR_CAP1]  = (rd || wr) && (a == `TPM_A_IC1L);
        flag_clr[`TPM_SR_CMP1]  = (rd || wr) && (a == `TPM_A_OC1L);
        flag_clr[`TPM_SR_OVF]   = (rd || wr) && (a == `TPM_A_CNTL);
        flag_clr[`TPM_SR_CAP2]  = (rd || wr) && (a == `TPM_A_IC2L);
        flag_clr[`TPM_SR_CMP2]  = (rd || wr) && (a == `TPM_A_OC2L);
    end

    // Status flags, set beats clear
    for (genvar i = `TPM_SR_CMP2; i <= `TPM_SR_CAP1; i++) begin : g_flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flag_q[i]    <= 1'b0;
                clr_arm_q[i] <= 1'b0;
            end else begin
                if (flag_set[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (flag_clr[i] && clr_arm_q[i]) begin
                    flag_q[i] <= 1'b0;
                end
                if (rd && (a == `TPM_A_SR) && flag_q[i]) begin
                    clr_arm_q[i] <= 1'b1;
                end else if (flag_clr[i]) begin
                    clr_arm_q[i] <= 1'b0;
                end
            end
        end
    end
    for (genvar i = 0; i < `TPM_SR_CMP2; i++) begin : g_nofl
        assign flag_q[i]    = 1'b0;
        assign clr_arm_q[i] = 1'b0;
    end

    // Control registers and disable bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr1_q <= `TPM_CR_RST;
            cr2_q <= `TPM_CR_RST;
            dis_q <= 1'b0;
        end else if (wr) begin
            if (a == `TPM_A_CR1) begin
                cr1_q <= wdata;
            end
            if (a == `TPM_A_CR2) begin
                cr2_q <= wdata;
            end
            if (a == `TPM_A_SR) begin
                dis_q <= wdata[`TPM_SR_DIS];
            end
        end
    end

    // First waveform latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_q <= 1'b0;
        end else begin
            case (mode)
                TPM_NORMAL: begin
                    if (cr1_q[`TPM_CR1_FORCE1] || cmp1_if.match) begin
                        pin1_q <= cr1_q[`TPM_CR1_LVL1];
                    end
                end
                TPM_ONEP: begin
                    if (trig) begin
                        pin1_q <= cr1_q[`TPM_CR1_LVL2];
                    end else if (cmp1_if.match) begin
                        pin1_q <= cr1_q[`TPM_CR1_LVL1];
                    end
                end
                TPM_PWM: begin
                    if (cmp2_if.match) begin
                        pin1_q <= cr1_q[`TPM_CR1_LVL2];
                    end else if (cmp1_if.match) begin
                        pin1_q <= cr1_q[`TPM_CR1_LVL1];
                    end
                end
                default: begin
                    pin1_q <= pin1_q;
                end
            endcase
        end
    end

    // Second waveform latch, normal mode only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin2_q <= 1'b0;
        end else if (mode == TPM_NORMAL) begin
            if (cr1_q[`TPM_CR1_FORCE2] || cmp2_if.match) begin
                pin2_q <= cr1_q[`TPM_CR1_LVL2];
            end
        end
    end

    // Pin enables, dropped while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe1_q <= 1'b0;
            oe2_q <= 1'b0;
        end else begin
            oe1_q <= cr2_q[`TPM_CR2_PIN1_EN] && !dis_q;
            oe2_q <= cr2_q[`TPM_CR2_PIN2_EN] && !dis_q && (mode == TPM_NORMAL);
        end
    end

    // Shared interrupt request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= !cpu_mask
                  && ((cr1_q[`TPM_CR1_CAP_IE] && (flag_q[`TPM_SR_CAP1] || flag_q[`TPM_SR_CAP2]))
                   || (cr1_q[`TPM_CR1_CMP_IE] && (flag_q[`TPM_SR_CMP1] || flag_q[`TPM_SR_CMP2]))
                   || (cr1_q[`TPM_CR1_OVF_IE] && flag_q[`TPM_SR_OVF]));
        end
    end

    // Read selection
    always_comb begin
        case (a)
            `TPM_A_CR1:   rd_mux = cr1_q;
            `TPM_A_CR2:   rd_mux = cr2_q;
            `TPM_A_SR:    rd_mux = {flag_q[7:3], dis_q, 2'h0};
            `TPM_A_IC1H:  rd_mux = ic1_q[15:8];
            `TPM_A_IC1L:  rd_mux = ic1_q[7:0];
            `TPM_A_OC1H:  rd_mux = cmp1_if.value[15:8];
            `TPM_A_OC1L:  rd_mux = cmp1_if.value[7:0];
            `TPM_A_CNTH:  rd_mux = cnt_q[15:8];
            `TPM_A_CNTL:  rd_mux = cnt_q[7:0];
            `TPM_A_ACNTH: rd_mux = cnt_q[15:8];
            `TPM_A_ACNTL: rd_mux = cnt_q[7:0];
            `TPM_A_IC2H:  rd_mux = ic2_q[15:8];
            `TPM_A_IC2L:  rd_mux = ic2_q[7:0];
            `TPM_A_OC2H:  rd_mux = cmp2_if.value[15:8];
            `TPM_A_OC2L:  rd_mux = cmp2_if.value[7:0];
            default:      rd_mux = 8'h00;
        endcase
        if (addr[ADDR_W-1:0] > ADDR_W'(15)) begin
            rd_mux = 8'h00;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rd_mux : 8'h00;
        end
    end

    assign rdata       = rdata_q;
    assign cmp1_pin_o  = pin1_q;
    assign cmp1_pin_oe = oe1_q;
    assign cmp2_pin_o  = pin2_q;
    assign cmp2_pin_oe = oe2_q;
    assign irq         = irq_q;
endmodule : tpm_timer
`default_nettype wire
